// [rtl/usb_control_endpoint_mode_responder.v]
// control endpoint token responder: mode decode, handshake choice, flag and count update
// Operation
// R1: a 4-bit mode field in the mode register selects token handling.
// R2: mode 0001 accepts SETUP and NAKs IN and OUT, no interrupt for NAKs.
// R3: status-check OUT is ACKed only with zero payload and toggle one.
// R4: failed status check gives STALL or no reply.
// R5: TX count mode sends the 4-bit programmed byte count per IN.
// R6: valid SETUP up to 10 bytes: ACK, S and A flags, mode 0001, data, interrupt.
// R7: SETUP over 10 bytes or invalid: no reply, no state change.
// R8: control OUT over 10 bytes or invalid is silently ignored.
// R9: mode 0011 STALLs IN and valid OUT with no state change.
// R10: mode 1111 IN acknowledged by host: I and A flags, mode 0001, interrupt.
// R11: mode 1111 IN not acknowledged: nothing changes, data resent next IN.
// R12: mode 1111 good status OUT: ACK, O and A, mode 0010, toggle 1, count 2.
// R13: mode 1111 bad status OUT: STALL, mode 0011, interrupt.
// R14: mode 0010 IN: STALL, mode 0011, interrupt.
// R15: mode 0010 good status OUT ACKed keeping mode; bad one STALLed to 0011.
// R16: mode 0000 ignores all traffic to the endpoint.
// R17: mode 1011 ACKs OUT data and sends zero-length data for IN.
// R18: firmware rewrites the mode after each interrupting transaction.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "usb_ep0_regs.vh"
module usb_control_endpoint_mode_responder (
   input wire i_clk,
   input wire i_sys_rst,
   // register port
   input wire [3:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output wire [7:0] o_rdata,
   // packet bytes from the serial interface engine
   input wire i_rx_we,
   input wire [2:0] i_rx_idx,
   input wire [7:0] i_rx_data,
   // end of token / packet summary
   input wire i_tok_valid,
   input wire [1:0] i_tok_kind,
   input wire [4:0] i_rx_len,
   input wire i_rx_ok,
   input wire i_rx_tog,
   // host handshake after transmitted IN data
   input wire i_host_ack,
   input wire i_host_timeout,
   // reply toward the serial interface engine
   output wire o_resp_valid,
   output wire [2:0] o_resp_code,
   output wire [3:0] o_tx_count,
   input wire [2:0] i_tx_idx,
   output wire [7:0] o_tx_byte,
   output wire o_irq
);
   reg [7:0] mode_reg_ff;
   reg [7:0] count_reg_ff;
   reg [`IRQ_WIDTH-1:0] irq_stat_ff;
   reg [`IRQ_WIDTH-1:0] irq_mask_ff;
   reg in_pend_ff;
   reg [3:0] pend_next_mode_ff;
   reg [7:0] rdata_ff;
   reg resp_valid_ff;
   reg [2:0] resp_code_ff;
   reg [3:0] tx_count_ff;
   reg [7:0] tx_byte_ff;
   reg irq_ff;
   wire [63:0] buf_bytes;
   wire [3:0] mode;
   wire len_ok;
   wire status_good;
   wire bus_buf_we;

   // decision outputs of the token table
   reg [2:0] nxt_resp;
   reg upd;
   reg [3:0] nxt_mode;
   reg set_s;
   reg set_i;
   reg set_o;
   reg set_a;
   reg upd_cnt;
   reg [3:0] nxt_cnt;
   reg nxt_tog;
   reg ev_irq;
   reg ev_stall;
   reg nxt_pend;
   reg [3:0] nxt_pend_mode;
   reg [7:0] nxt_mode_reg;
   reg [7:0] nxt_count_reg;
   reg [`IRQ_WIDTH-1:0] nxt_irq_stat;
   reg [`IRQ_WIDTH-1:0] irq_set;

   assign mode = mode_reg_ff[`MODE_MSB:`MODE_LSB]; // [R1]
   assign len_ok = (i_rx_len <= `MAX_PKT_LEN) && i_rx_ok;
   assign status_good = (i_rx_len == `STATUS_PKT_LEN) && i_rx_tog; // [R3]
   assign bus_buf_we = i_wr && i_addr[3];

   ep0_buffer u_buf (
      .i_clk(i_clk),
      .i_rx_we(i_rx_we),
      .i_rx_idx(i_rx_idx),
      .i_rx_data(i_rx_data),
      .i_bus_we(bus_buf_we),
      .i_bus_idx(i_addr[2:0]),
      .i_bus_data(i_wdata),
      .o_bytes(buf_bytes)
   );

   // token table: one decision per token, only for control modes
   always @* begin
      nxt_resp = `RESP_NONE;
      upd = 1'b0;
      nxt_mode = mode;
      set_s = 1'b0;
      set_i = 1'b0;
      set_o = 1'b0;
      set_a = 1'b0;
      upd_cnt = 1'b0;
      nxt_cnt = i_rx_len[3:0];
      nxt_tog = i_rx_tog;
      ev_irq = 1'b0;
      ev_stall = 1'b0;
      nxt_pend = 1'b0;
      nxt_pend_mode = mode;
      if (i_tok_valid) begin
         case (mode)
            `MODE_NAK_INOUT, `MODE_STATUS_OUT, `MODE_STALL_INOUT, `MODE_STATUS_IN,
            `MODE_ACKOUT_STIN, `MODE_ACKIN_STOUT: begin
               if (i_tok_kind == `TOK_SETUP) begin
                  if (len_ok) begin
                     // accepted setup re-arms to nak both ways
                     nxt_resp = `RESP_ACK; // [R6]
                     upd = 1'b1;
                     nxt_mode = `MODE_NAK_INOUT;
                     set_s = 1'b1;
                     set_a = 1'b1;
                     upd_cnt = 1'b1;
                     ev_irq = 1'b1;
                  end
                  // oversize or corrupt setup: silence, buffer may hold junk [R7]
               end else if (i_tok_kind == `TOK_IN) begin
                  case (mode)
                     `MODE_NAK_INOUT: nxt_resp = `RESP_NAK; // [R2]
                     `MODE_STALL_INOUT: nxt_resp = `RESP_STALL; // [R9]
                     `MODE_STATUS_OUT: begin
                        nxt_resp = `RESP_STALL; // [R14]
                        upd = 1'b1;
                        nxt_mode = `MODE_STALL_INOUT;
                        ev_irq = 1'b1;
                        ev_stall = 1'b1;
                     end
                     `MODE_ACKIN_STOUT: begin
                        nxt_resp = `RESP_TX_COUNT; // [R5]
                        nxt_pend = 1'b1;
                        nxt_pend_mode = `MODE_NAK_INOUT; // [R10]
                     end
                     default: begin
                        nxt_resp = `RESP_TX_ZERO; // [R17]
                        nxt_pend = 1'b1;
                        nxt_pend_mode = `MODE_STALL_INOUT;
                     end
                  endcase
               end else if (i_tok_kind == `TOK_OUT && len_ok) begin
                  case (mode)
                     `MODE_NAK_INOUT: nxt_resp = `RESP_NAK; // [R2]
                     `MODE_STALL_INOUT: nxt_resp = `RESP_STALL; // [R9]
                     `MODE_STATUS_IN: begin
                        nxt_resp = `RESP_STALL;
                        upd = 1'b1;
                        nxt_mode = `MODE_STALL_INOUT;
                        ev_irq = 1'b1;
                        ev_stall = 1'b1;
                     end
                     `MODE_ACKOUT_STIN: begin
                        nxt_resp = `RESP_ACK; // [R17]
                        upd = 1'b1;
                        nxt_mode = `MODE_NAK_INOUT;
                        set_o = 1'b1;
                        set_a = 1'b1;
                        upd_cnt = 1'b1;
                        ev_irq = 1'b1;
                     end
                     default: begin
                        // status-check modes 1111 and 0010
                        upd = 1'b1;
                        ev_irq = 1'b1;
                        if (status_good) begin
                           nxt_resp = `RESP_ACK; // [R12] [R15]
                           set_o = 1'b1;
                           set_a = 1'b1;
                           upd_cnt = 1'b1;
                           nxt_cnt = 4'h2;
                           nxt_tog = 1'b1;
                           nxt_mode = `MODE_STATUS_OUT;
                        end else begin
                           nxt_resp = `RESP_STALL; // [R4] [R13] [R15]
                           nxt_mode = `MODE_STALL_INOUT;
                           ev_stall = 1'b1;
                        end
                     end
                  endcase
               end
               // oversize or corrupt OUT falls through silently [R8]
            end
            default: nxt_resp = `RESP_NONE; // disabled, data and reserved modes [R16]
         endcase
      end
   end

   // register next values; hardware updates win over a same-cycle software write
   always @* begin
      nxt_mode_reg = mode_reg_ff;
      nxt_count_reg = count_reg_ff;
      nxt_irq_stat = irq_stat_ff;
      irq_set = {`IRQ_WIDTH{1'b0}};
      if (i_wr && i_addr == `EP0_MODE_ADDR) begin
         nxt_mode_reg = i_wdata; // firmware re-arms here [R18]
      end
      if (i_wr && i_addr == `EP0_COUNT_ADDR) begin
         nxt_count_reg = i_wdata;
      end
      if (i_rd && i_addr == `EP0_IRQ_STAT_ADDR) begin
         nxt_irq_stat = {`IRQ_WIDTH{1'b0}};
      end
      if (upd) begin
         nxt_mode_reg[`MODE_MSB:`MODE_LSB] = nxt_mode;
      end
      if (set_s) nxt_mode_reg[`FLAG_SETUP_BIT] = 1'b1;
      if (set_o) nxt_mode_reg[`FLAG_OUT_BIT] = 1'b1;
      if (set_a) nxt_mode_reg[`FLAG_ACK_BIT] = 1'b1;
      if (upd_cnt) begin
         nxt_count_reg[`CNT_MSB:`CNT_LSB] = nxt_cnt;
         nxt_count_reg[`CNT_DVAL_BIT] = 1'b1;
         nxt_count_reg[`CNT_TOG_BIT] = nxt_tog;
      end
      // host ack of transmitted IN data closes the pending transfer [R10]
      if (in_pend_ff && i_host_ack) begin
         nxt_mode_reg[`MODE_MSB:`MODE_LSB] = pend_next_mode_ff;
         nxt_mode_reg[`FLAG_IN_BIT] = 1'b1;
         nxt_mode_reg[`FLAG_ACK_BIT] = 1'b1;
         irq_set[`IRQ_EP_BIT] = 1'b1;
      end
      if (ev_irq) irq_set[`IRQ_EP_BIT] = 1'b1;
      if (set_s) irq_set[`IRQ_SETUP_BIT] = 1'b1;
      if (ev_stall) irq_set[`IRQ_STALL_BIT] = 1'b1;
      nxt_irq_stat = nxt_irq_stat | irq_set; // set wins over read-clear
   end

   // state, reply and interrupt flops
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         mode_reg_ff <= `MODE_REG_RST;
         count_reg_ff <= `COUNT_REG_RST;
         irq_stat_ff <= {`IRQ_WIDTH{1'b0}};
         irq_mask_ff <= `IRQ_MASK_RST;
         in_pend_ff <= 1'b0;
         pend_next_mode_ff <= `MODE_DISABLE;
         resp_valid_ff <= 1'b0;
         resp_code_ff <= `RESP_NONE;
         tx_count_ff <= 4'h0;
         irq_ff <= 1'b0;
      end else begin
         mode_reg_ff <= nxt_mode_reg;
         count_reg_ff <= nxt_count_reg;
         irq_stat_ff <= nxt_irq_stat;
         if (i_wr && i_addr == `EP0_IRQ_MASK_ADDR) begin
            irq_mask_ff <= i_wdata[`IRQ_WIDTH-1:0];
         end
         // an unacked IN leaves everything as is for a resend [R11]
         if (i_tok_valid) begin
            in_pend_ff <= nxt_pend;
            pend_next_mode_ff <= nxt_pend_mode;
         end else if (i_host_ack || i_host_timeout) begin
            in_pend_ff <= 1'b0; // [R11]
         end
         resp_valid_ff <= i_tok_valid;
         resp_code_ff <= nxt_resp;
         // zero-length reply carries count zero
         tx_count_ff <= (nxt_resp == `RESP_TX_COUNT) ? count_reg_ff[`CNT_MSB:`CNT_LSB] : 4'h0; // [R5]
         irq_ff <= |(nxt_irq_stat & irq_mask_ff);
      end
   end

   // read data one cycle after the strobe; unmapped reads return zero
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         rdata_ff <= 8'h00;
         tx_byte_ff <= 8'h00;
      end else begin
         tx_byte_ff <= buf_bytes[i_tx_idx*8 +: 8];
         if (!i_rd) begin
            rdata_ff <= 8'h00;
         end else if (i_addr[3]) begin
            rdata_ff <= buf_bytes[i_addr[2:0]*8 +: 8];
         end else begin
            case (i_addr)
               `EP0_MODE_ADDR: rdata_ff <= mode_reg_ff;
               `EP0_COUNT_ADDR: rdata_ff <= count_reg_ff;
               `EP0_IRQ_STAT_ADDR: rdata_ff <= {5'h00, irq_stat_ff};
               `EP0_IRQ_MASK_ADDR: rdata_ff <= {5'h00, irq_mask_ff};
               default: rdata_ff <= 8'h00;
            endcase
         end
      end
   end

   assign o_rdata = rdata_ff;
   assign o_resp_valid = resp_valid_ff;
   assign o_resp_code = resp_code_ff;
   assign o_tx_count = tx_count_ff;
   assign o_tx_byte = tx_byte_ff;
   assign o_irq = irq_ff;
endmodule
`default_nettype wire

// [rtl/usb_ep0_regs.vh]
// register offsets, field positions and codes of the control endpoint responder
`ifndef USB_EP0_REGS_VH
`define USB_EP0_REGS_VH

// register indexes on the 4-bit register port
`define EP0_MODE_ADDR 4'h0
`define EP0_COUNT_ADDR 4'h1
`define EP0_IRQ_STAT_ADDR 4'h2
`define EP0_IRQ_MASK_ADDR 4'h3
`define EP0_BUF_BASE 4'h8

// mode register fields
`define MODE_LSB 0
`define MODE_MSB 3
`define FLAG_ACK_BIT 4
`define FLAG_OUT_BIT 5
`define FLAG_IN_BIT 6
`define FLAG_SETUP_BIT 7

// count register fields
`define CNT_LSB 0
`define CNT_MSB 3
`define CNT_DVAL_BIT 6
`define CNT_TOG_BIT 7

// interrupt status fields
`define IRQ_EP_BIT 0
`define IRQ_SETUP_BIT 1
`define IRQ_STALL_BIT 2
`define IRQ_WIDTH 3

// reset values
`define MODE_REG_RST 8'h00
`define COUNT_REG_RST 8'h00
`define IRQ_MASK_RST 3'h0

// endpoint mode encodings
`define MODE_DISABLE 4'h0
`define MODE_NAK_INOUT 4'h1
`define MODE_STATUS_OUT 4'h2
`define MODE_STALL_INOUT 4'h3
`define MODE_STATUS_IN 4'h6
`define MODE_ACKOUT_STIN 4'hb
`define MODE_ACKIN_STOUT 4'hf

// token kinds from the serial interface engine
`define TOK_SETUP 2'h1
`define TOK_IN 2'h2
`define TOK_OUT 2'h3

// handshake / reply codes toward the serial interface engine
`define RESP_NONE 3'h0
`define RESP_ACK 3'h1
`define RESP_NAK 3'h2
`define RESP_STALL 3'h3
`define RESP_TX_COUNT 3'h4
`define RESP_TX_ZERO 3'h5

// packet length limits
`define MAX_PKT_LEN 5'h0a
`define STATUS_PKT_LEN 5'h02

`endif

// [rtl/ep0_buffer.v]
// eight-byte endpoint buffer with a receive write port and a register write port
`timescale 1ns/10ps
`default_nettype none
module ep0_buffer (
   input wire i_clk,
   input wire i_rx_we,
   input wire [2:0] i_rx_idx,
   input wire [7:0] i_rx_data,
   input wire i_bus_we,
   input wire [2:0] i_bus_idx,
   input wire [7:0] i_bus_data,
   output wire [63:0] o_bytes
);
   reg [7:0] mem_ff [0:7];
   genvar g;

   // receive side wins when both write the same byte in one cycle, contents are not reset
   always @(posedge i_clk) begin
      if (i_rx_we) begin
         mem_ff[i_rx_idx] <= i_rx_data;
      end
      if (i_bus_we && !(i_rx_we && i_rx_idx == i_bus_idx)) begin
         mem_ff[i_bus_idx] <= i_bus_data;
      end
   end

   // flatten for the reader
   generate
      for (g = 0; g < 8; g = g + 1) begin : flat
         assign o_bytes[g*8 +: 8] = mem_ff[g];
      end
   endgenerate
endmodule
`default_nettype wire

// [tb/usb_ep0_monitor.sv]
// port-level assertions for the control endpoint responder
`timescale 1ns/10ps
`default_nettype none
`include "usb_ep0_regs.vh"
module usb_ep0_monitor (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_tok_valid,
   input wire logic [1:0] i_tok_kind,
   input wire logic [4:0] i_rx_len,
   input wire logic i_rx_ok,
   input wire logic o_resp_valid,
   input wire logic [2:0] o_resp_code,
   input wire logic [3:0] o_tx_count,
   input wire logic o_irq
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   logic wrote_ff;
   // mode can only leave disabled through a software write
   always @(posedge i_clk) begin
      wrote_ff <= i_sys_rst ? 1'b0 : (wrote_ff | (i_wr && i_addr == `EP0_MODE_ADDR));
   end
   sequence s_tok(k);
      i_tok_valid && i_tok_kind == k;
   endsequence
   // quiet gap matches the host model's token spacing
   sequence s_gap;
      (!i_wr && !i_tok_valid) [*2];
   endsequence
   sequence s_setup_acked;
      s_tok(`TOK_SETUP) ##1 o_resp_valid && o_resp_code == `RESP_ACK && !i_wr && !i_tok_valid;
   endsequence
   sequence s_stalled;
      i_tok_valid && !i_wr ##1 o_resp_valid && o_resp_code == `RESP_STALL && !i_wr && !i_tok_valid;
   endsequence
   property p_resp_cause;
      !i_tok_valid |=> !o_resp_valid;
   endproperty
   a_resp_cause: assert property (p_resp_cause) else $error("reply without token");
   property p_read_idle;
      !i_rd |=> o_rdata == 8'h00;
   endproperty
   a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");
   property p_bad_setup;
      i_tok_valid && i_tok_kind == `TOK_SETUP && (i_rx_len > `MAX_PKT_LEN || !i_rx_ok) |=> o_resp_code == `RESP_NONE;
   endproperty
   a_bad_setup: assert property (p_bad_setup) else $error("bad setup answered");
   property p_bad_out;
      i_tok_valid && i_tok_kind == `TOK_OUT && (i_rx_len > `MAX_PKT_LEN || !i_rx_ok) |=> o_resp_code == `RESP_NONE;
   endproperty
   a_bad_out: assert property (p_bad_out) else $error("bad out answered");
   property p_disabled;
      i_tok_valid && !wrote_ff |=> o_resp_code == `RESP_NONE;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled endpoint answered");
   property p_nak_after_setup;
      s_setup_acked ##1 s_gap ##1 s_tok(`TOK_IN) |=> o_resp_code == `RESP_NAK;
   endproperty
   a_nak_after_setup: assert property (p_nak_after_setup) else $error("in after setup not nak");
   property p_nak_quiet;
      o_resp_valid && o_resp_code == `RESP_NAK && !$past(i_wr) |-> !$rose(o_irq);
   endproperty
   a_nak_quiet: assert property (p_nak_quiet) else $error("nak raised interrupt");
   property p_stall_holds;
      s_stalled ##1 s_gap ##1 s_tok(`TOK_IN) |=> o_resp_code == `RESP_STALL;
   endproperty
   a_stall_holds: assert property (p_stall_holds) else $error("stall state left");
   property p_count_only_tx;
      o_resp_code != `RESP_TX_COUNT |-> o_tx_count == 4'h0;
   endproperty
   a_count_only_tx: assert property (p_count_only_tx) else $error("count without transmit");
endmodule
bind usb_control_endpoint_mode_responder usb_ep0_monitor i_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tok_valid(i_tok_valid),
   .i_tok_kind(i_tok_kind), .i_rx_len(i_rx_len), .i_rx_ok(i_rx_ok), .o_resp_valid(o_resp_valid),
   .o_resp_code(o_resp_code), .o_tx_count(o_tx_count), .o_irq(o_irq));
`default_nettype wire

// [tb/usb_host_model.sv]
// host stand-in: sends tokens and handshakes transmitted data
`timescale 1ns/10ps
`default_nettype none
`include "usb_ep0_regs.vh"
module usb_host_model (
   input wire logic i_clk,
   input wire logic [2:0] i_resp_code,
   output logic o_tok_valid,
   output logic [1:0] o_tok_kind,
   output logic [4:0] o_len,
   output logic o_ok,
   output logic o_tog,
   output logic o_ack,
   output logic o_timeout,
   output logic o_rx_we,
   output logic [7:0] o_rx_data
);
   logic ack_en = 1'b1; // cleared by the bench to withhold the handshake
   initial begin
      {o_tok_valid, o_tok_kind, o_len, o_ok, o_tog, o_ack, o_timeout, o_rx_we, o_rx_data} = '0;
   end
   // data byte first, then the token; idle qualifiers are inverted so stale values never match the last token
   task automatic token(input logic [1:0] kind, input logic [4:0] len, input logic ok, input logic tog);
      @(posedge i_clk);
      o_rx_we <= (kind != `TOK_IN);
      o_rx_data <= 8'($urandom);
      @(posedge i_clk);
      o_rx_we <= 1'b0;
      o_tok_valid <= 1'b1;
      {o_tok_kind, o_len, o_ok, o_tog} <= {kind, len, ok, tog};
      @(posedge i_clk);
      o_tok_valid <= 1'b0;
      {o_tok_kind, o_len, o_ok, o_tog} <= ~{kind, len, ok, tog};
      @(posedge i_clk);
      // host handshakes or pulses a timeout after data it received
      if (i_resp_code == `RESP_TX_COUNT || i_resp_code == `RESP_TX_ZERO) begin
         repeat (2) @(posedge i_clk);
         o_ack <= ack_en;
         o_timeout <= !ack_en;
         @(posedge i_clk);
         o_ack <= 1'b0;
         o_timeout <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// [tb/test_usb_control_endpoint_mode_responder.sv]
// self-checking bench of the control endpoint responder
`timescale 1ns/10ps
`default_nettype none
`include "usb_ep0_regs.vh"
module test_usb_control_endpoint_mode_responder;
   localparam logic [7:0] e_none = 8'h00;
   localparam logic [7:0] e_ack = {1'b0, `RESP_ACK, 4'h0};
   localparam logic [7:0] e_nak = {1'b0, `RESP_NAK, 4'h0};
   localparam logic [7:0] e_stl = {1'b0, `RESP_STALL, 4'h0};
   localparam logic [7:0] e_tx0 = {1'b0, `RESP_TX_ZERO, 4'h0};
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic rd_seen = 1'b0;
   logic [2:0] tx_idx = 3'h0;
   logic [4:0] n;
   logic t;
   logic [7:0] q_rsp[$];
   logic [7:0] q_rd[$];
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   wire [7:0] o_rdata, o_tx_byte, rx_data;
   wire o_resp_valid, o_irq, tok_valid, rx_ok, rx_tog, host_ack, host_to, rx_we;
   wire [2:0] o_resp_code;
   wire [3:0] o_tx_count;
   wire [1:0] tok_kind;
   wire [4:0] rx_len;
   always #4 i_clk = ~i_clk;
   usb_control_endpoint_mode_responder i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_we(rx_we), .i_rx_idx(3'h0),
      .i_rx_data(rx_data), .i_tok_valid(tok_valid), .i_tok_kind(tok_kind), .i_rx_len(rx_len),
      .i_rx_ok(rx_ok), .i_rx_tog(rx_tog), .i_host_ack(host_ack), .i_host_timeout(host_to),
      .o_resp_valid(o_resp_valid), .o_resp_code(o_resp_code), .o_tx_count(o_tx_count), .i_tx_idx(tx_idx),
      .o_tx_byte(o_tx_byte), .o_irq(o_irq));
   usb_host_model i_host (.i_clk(i_clk), .i_resp_code(o_resp_code), .o_tok_valid(tok_valid),
      .o_tok_kind(tok_kind), .o_len(rx_len), .o_ok(rx_ok), .o_tog(rx_tog), .o_ack(host_ack),
      .o_timeout(host_to), .o_rx_we(rx_we), .o_rx_data(rx_data));
   task automatic conclude();
      // a note still queued means an expected result never showed up
      if (q_rsp.size() != 0 || q_rd.size() != 0) num_errors++;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one compare per kind of result, all tallied by chk
   task automatic chk_resp(input logic [7:0] e, input logic [7:0] g);
      chk("resp", e, g);
   endtask
   task automatic chk_rdata(input logic [7:0] e, input logic [7:0] g);
      chk("rdata", e, g);
   endtask
   task automatic chk_irq(input logic e);
      chk("irq", {7'h00, e}, {7'h00, o_irq});
   endtask
   task automatic chk_tx(input logic [7:0] e);
      chk("tx_byte", e, o_tx_byte);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      q_rd.push_back(e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic tok(input logic [1:0] k, input logic [4:0] l, input logic ok, input logic tg,
      input logic [7:0] e);
      q_rsp.push_back(e);
      i_host.token(k, l, ok, tg);
   endtask
   // watcher: each reply or read result is matched with the oldest note; also cuts a hang short
   always @(posedge i_clk) begin
      rd_seen <= i_rd;
      if (o_resp_valid === 1'b1) chk_resp(q_rsp.pop_front(), {1'b0, o_resp_code, o_tx_count});
      if (rd_seen) chk_rdata(q_rd.pop_front(), o_rdata);
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         num_errors++;
         conclude();
      end
   end
   // main sequence, one group per behaviour
   initial begin
      void'($urandom(32'h9178));
      n = 5'($urandom_range(10));
      t = 1'($urandom);
      repeat (12) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      wr(4'h5, 8'h5a);
      for (int a = 0; a < 6; a++) rd(4'(a), 8'h00);
      tok(`TOK_SETUP, 5'h08, 1'b1, 1'b1, e_none);
      tok(`TOK_IN, 5'h00, 1'b1, 1'b0, e_none);
      $display("disabled mode done");
      wr(4'h0, 8'h01);
      wr(4'h3, 8'h07);
      tok(`TOK_SETUP, 5'h0b, 1'b1, 1'b0, e_none);
      tok(`TOK_SETUP, 5'h04, 1'b0, 1'b0, e_none);
      tok(`TOK_SETUP, n, 1'b1, t, e_ack);
      tok(`TOK_IN, 5'h00, 1'b1, 1'b0, e_nak);
      tok(`TOK_OUT, 5'h02, 1'b1, 1'b1, e_nak);
      tok(`TOK_OUT, 5'h0b, 1'b1, 1'b1, e_none);
      @(negedge i_clk);
      chk_irq(1'b1);
      rd(4'h0, 8'h91);
      rd(4'h1, {t, 1'b1, 2'b00, n[3:0]});
      rd(4'h8, rx_data);
      // bus write into the buffer, then the transmit port reads it back
      wr(4'hb, 8'h3c);
      tx_idx <= 3'h3;
      rd(4'hb, 8'h3c);
      @(negedge i_clk);
      chk_tx(8'h3c);
      rd(4'h2, 8'h03);
      @(negedge i_clk);
      chk_irq(1'b0);
      $display("setup and nak done");
      wr(4'h1, 8'h05);
      wr(4'h0, 8'h0f);
      i_host.ack_en = 1'b0;
      tok(`TOK_IN, 5'h00, 1'b1, 1'b0, {1'b0, `RESP_TX_COUNT, 4'h5});
      rd(4'h0, 8'h0f);
      i_host.ack_en = 1'b1;
      tok(`TOK_IN, 5'h00, 1'b1, 1'b0, {1'b0, `RESP_TX_COUNT, 4'h5});
      rd(4'h0, 8'h51);
      rd(4'h2, 8'h01);
      wr(4'h0, 8'h0f);
      tok(`TOK_OUT, 5'h02, 1'b1, 1'b1, e_ack);
      rd(4'h0, 8'h32);
      rd(4'h1, 8'hc2);
      tok(`TOK_OUT, 5'h02, 1'b1, 1'b1, e_ack);
      rd(4'h0, 8'h32);
      rd(4'h2, 8'h01);
      $display("in data and status done");
      wr(4'h3, 8'h00);
      wr(4'h0, 8'h02);
      tok(`TOK_IN, 5'h00, 1'b1, 1'b0, e_stl);
      tok(`TOK_IN, 5'h00, 1'b1, 1'b0, e_stl);
      tok(`TOK_OUT, 5'h02, 1'b1, 1'b1, e_stl);
      rd(4'h0, 8'h03);
      @(negedge i_clk);
      chk_irq(1'b0);
      rd(4'h2, 8'h05);
      for (int i = 0; i < 2; i++) begin
         wr(4'h0, 8'h0f);
         tok(`TOK_OUT, 5'(2 + i), 1'b1, 1'(i), e_stl);
         rd(4'h0, 8'h03);
      end
      rd(4'h2, 8'h05);
      wr(4'h3, 8'h07);
      $display("stall modes done");
      wr(4'h0, 8'h0b);
      i_host.ack_en = 1'b0;
      tok(`TOK_IN, 5'h00, 1'b1, 1'b0, e_tx0);
      tok(`TOK_OUT, 5'h03, 1'b1, 1'b1, e_ack);
      rd(4'h0, 8'h31);
      // acknowledged zero-length reply parks the endpoint in stall
      i_host.ack_en = 1'b1;
      wr(4'h0, 8'h0b);
      tok(`TOK_IN, 5'h00, 1'b1, 1'b0, e_tx0);
      rd(4'h0, 8'h53);
      wr(4'h0, 8'h06);
      tok(`TOK_OUT, 5'h02, 1'b1, 1'b1, e_stl);
      rd(4'h0, 8'h03);
      $display("status in mode done");
      repeat (4) @(posedge i_clk);
      conclude();
   end
endmodule
`default_nettype wire
